//--- rtl/lamp_drive_pkg.sv
// Shared constants and types for the lamp output drive control block
package lamp_drive_pkg;

    // Number of lamp pins and width of each control field
    localparam int LAMPS = 2;

    // Register offsets
    localparam logic [7:0] ADDR_DRIVE_TYPE = 8'h71;
    localparam logic [7:0] ADDR_LINK       = 8'h72;
    localparam logic [7:0] ADDR_POLARITY   = 8'h73;
    localparam logic [7:0] ADDR_MANUAL     = 8'h74;

    // Reset values of the stored fields
    localparam logic [LAMPS-1:0] FIELD_RESET = 2'h0;
    localparam logic [7:0]       RDATA_RESET = 8'h00;

    // Duty resolution: one period is DUTY_TOP+1 clock cycles
    localparam int         DUTY_W    = 4;
    localparam logic [3:0] DUTY_TOP  = 4'hF;
    localparam logic [3:0] DUTY_ZERO = 4'h0;
    localparam logic [3:0] DUTY_STEP = 4'h1;

    typedef logic [DUTY_W-1:0] duty_t;

    // Register access request from the serial interface core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Duty settings handed in by the behaviour logic per lamp
    typedef struct packed {
        logic  breathe;
        duty_t max_duty;
        duty_t min_duty;
    } lamp_duty_t;

    // Pin drive: level driven and active-low output enable
    typedef struct packed {
        logic level;
        logic oe_n;
    } pin_drive_t;

    // Breathing ramp phase, one-hot
    typedef enum logic [2:0] {
        RAMP_HOLD = 3'b001,
        RAMP_UP   = 3'b010,
        RAMP_DOWN = 3'b100
    } ramp_state_t;

endpackage

//--- rtl/lamp_output_drive_control.sv
// Output stage control for two lamp driver pins with touch linking
//
// How it works
// - Drive-type bit zero: pin open-drain, low when driven, released otherwise.
// - Drive-type bit one: pin push-pull, driven high for one, low for zero.
// - Drive-type register: bit one for lamp b, bit zero for lamp a.
// - Link bit one set: touch on sensor b actuates lamp b with its behaviour.
// - Link bit clear: touches ignored, lamp follows its manual drive bit.
// - Link bit zero ties lamp a to sensor a the same way.
// - Linked touch acts as manual drive one; polarity applied afterwards.
// - Duty gives time at logic one non-inverted, logic zero inverted.
// - Breathing ramps duty from minimum up to maximum then back down.
// - No touch and manual bit zero: lamp runs at minimum duty.
// - Polarity zero (default, inverted): duty counts time at logic zero.
// - Polarity one (non-inverted): duty counts time at logic one or release.
// - Polarity register: bit one for lamp b, bit zero for lamp a.
// - Linked lamps run from sensor events regardless of manual bits.
// - Unlinked lamp uses its manual drive bit to decide actuation.
// - Manual bit zero gives minimum duty; one actuates up to maximum duty.
// - Manual drive register: bit one for lamp b, bit zero for lamp a.
// - Non-inverted lamp is lit for one hundred percent minus the duty.
`timescale 1ns/1ps
`default_nettype none

module lamp_output_drive_control
(
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       ce,
    input  wire lamp_drive_pkg::reg_req_t   reg_req,
    output var  logic [7:0]                 reg_rdata,
    input  wire logic                       touch_input_a,
    input  wire logic                       touch_input_b,
    input  wire lamp_drive_pkg::lamp_duty_t duty_a,
    input  wire lamp_drive_pkg::lamp_duty_t duty_b,
    output var  logic                       lamp_actuate_a,
    output var  logic                       lamp_actuate_b,
    output var  lamp_drive_pkg::pin_drive_t lamp_out_a,
    output var  lamp_drive_pkg::pin_drive_t lamp_out_b
);

    localparam int N = lamp_drive_pkg::LAMPS;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [N-1:0] type_reg;
    logic [N-1:0] type_next;
    logic [N-1:0] link_reg;
    logic [N-1:0] link_next;
    logic [N-1:0] pol_reg;
    logic [N-1:0] pol_next;
    logic [N-1:0] manual_reg;
    logic [N-1:0] manual_next;
    logic [7:0]   rdata_reg;
    logic [7:0]   rdata_next;

    // Only the low field bits are stored; the rest never exist
    always_comb
    begin
        type_next   = type_reg;
        link_next   = link_reg;
        pol_next    = pol_reg;
        manual_next = manual_reg;
        rdata_next  = rdata_reg;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                lamp_drive_pkg::ADDR_DRIVE_TYPE:
                    type_next = reg_req.wdata[N-1:0];
                lamp_drive_pkg::ADDR_LINK:
                    link_next = reg_req.wdata[N-1:0];
                lamp_drive_pkg::ADDR_POLARITY:
                    pol_next = reg_req.wdata[N-1:0];
                lamp_drive_pkg::ADDR_MANUAL:
                    manual_next = reg_req.wdata[N-1:0];
                default:
                    ;
            endcase
        end
        // Read data held until the next read; unmapped reads give zero
        if (reg_req.rd)
        begin
            rdata_next = lamp_drive_pkg::RDATA_RESET;
            unique case (reg_req.addr)
                lamp_drive_pkg::ADDR_DRIVE_TYPE:
                    rdata_next[N-1:0] = type_reg;
                lamp_drive_pkg::ADDR_LINK:
                    rdata_next[N-1:0] = link_reg;
                lamp_drive_pkg::ADDR_POLARITY:
                    rdata_next[N-1:0] = pol_reg;
                lamp_drive_pkg::ADDR_MANUAL:
                    rdata_next[N-1:0] = manual_reg;
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            type_reg   <= lamp_drive_pkg::FIELD_RESET;
            link_reg   <= lamp_drive_pkg::FIELD_RESET;
            pol_reg    <= lamp_drive_pkg::FIELD_RESET;
            manual_reg <= lamp_drive_pkg::FIELD_RESET;
            rdata_reg  <= lamp_drive_pkg::RDATA_RESET;
        end
        else if (ce)
        begin
            type_reg   <= type_next;
            link_reg   <= link_next;
            pol_reg    <= pol_next;
            manual_reg <= manual_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    AST_WRITE_TYPE: assert property (
        ce && reg_req.wr && reg_req.addr == lamp_drive_pkg::ADDR_DRIVE_TYPE
        |=> type_reg == $past(reg_req.wdata[N-1:0]))
        else $error("Drive type write not stored");

    AST_READ_UPPER_ZERO: assert property (
        ce && reg_req.rd |=> (rdata_reg >> N) == lamp_drive_pkg::RDATA_RESET)
        else $error("Upper read bits not zero");

    AST_READ_POL: assert property (
        ce && reg_req.rd && !reg_req.wr
        && reg_req.addr == lamp_drive_pkg::ADDR_POLARITY
        |=> rdata_reg[N-1:0] == $past(pol_reg))
        else $error("Polarity readback wrong");

    AST_WRITE_LINK: assert property (
        ce && reg_req.wr && reg_req.addr == lamp_drive_pkg::ADDR_LINK
        |=> link_reg == $past(reg_req.wdata[N-1:0]))
        else $error("Link write not stored");

    AST_WRITE_MANUAL: assert property (
        ce && reg_req.wr && reg_req.addr == lamp_drive_pkg::ADDR_MANUAL
        |=> manual_reg == $past(reg_req.wdata[N-1:0]))
        else $error("Manual drive write not stored");

    ////////////////////////////////////////////////////////////////////////
    // Shared duty counter: one duty period is DUTY_TOP+1 cycles

    lamp_drive_pkg::duty_t pwm_cnt_reg;
    lamp_drive_pkg::duty_t pwm_cnt_next;
    logic                  pwm_wrap;

    always_comb
    begin
        pwm_wrap     = (pwm_cnt_reg == lamp_drive_pkg::DUTY_TOP);
        pwm_cnt_next = pwm_cnt_reg + lamp_drive_pkg::DUTY_STEP;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pwm_cnt_reg <= lamp_drive_pkg::DUTY_ZERO;
        else if (ce)
            pwm_cnt_reg <= pwm_cnt_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per lamp: actuation source, duty ramp and pin drive

    logic [N-1:0]               touch;
    lamp_drive_pkg::lamp_duty_t duty      [N];
    logic [N-1:0]               act_reg;
    logic [N-1:0]               act_next;
    lamp_drive_pkg::pin_drive_t pin_reg   [N];
    lamp_drive_pkg::pin_drive_t pin_next  [N];
    lamp_drive_pkg::duty_t      level_reg [N];
    lamp_drive_pkg::duty_t      level_next[N];
    lamp_drive_pkg::ramp_state_t state_reg [N];
    lamp_drive_pkg::ramp_state_t state_next[N];
    logic [N-1:0]               pin_level;

    assign touch   = {touch_input_b, touch_input_a};
    assign duty[0] = duty_a;
    assign duty[1] = duty_b;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_lamp
            logic phase;

            // A linked touch counts exactly as a manual drive of one
            always_comb
            begin
                act_next[i] = link_reg[i] ? touch[i]
                                          : manual_reg[i];
            end

            // Duty level: minimum when idle, maximum when steady,
            // ramping min-max-min when breathing. A new breath always
            // restarts from the minimum so the ramp shape stays whole.
            always_comb
            begin
                level_next[i] = level_reg[i];
                state_next[i] = state_reg[i];
                if (!act_reg[i])
                begin
                    level_next[i] = duty[i].min_duty;
                    state_next[i] = lamp_drive_pkg::RAMP_HOLD;
                end
                else if (!duty[i].breathe)
                begin
                    level_next[i] = duty[i].max_duty;
                    state_next[i] = lamp_drive_pkg::RAMP_HOLD;
                end
                else
                begin
                    unique case (state_reg[i])
                        lamp_drive_pkg::RAMP_HOLD:
                        begin
                            level_next[i] = duty[i].min_duty;
                            state_next[i] = lamp_drive_pkg::RAMP_UP;
                        end
                        lamp_drive_pkg::RAMP_UP:
                            if (pwm_wrap)
                            begin
                                if (level_reg[i] >= duty[i].max_duty)
                                    state_next[i] = lamp_drive_pkg::RAMP_DOWN;
                                else
                                    level_next[i] = level_reg[i]
                                        + lamp_drive_pkg::DUTY_STEP;
                            end
                        lamp_drive_pkg::RAMP_DOWN:
                            if (pwm_wrap)
                            begin
                                if (level_reg[i] <= duty[i].min_duty)
                                    state_next[i] = lamp_drive_pkg::RAMP_UP;
                                else
                                    level_next[i] = level_reg[i]
                                        - lamp_drive_pkg::DUTY_STEP;
                            end
                        default:
                            state_next[i] = lamp_drive_pkg::RAMP_HOLD;
                    endcase
                end
            end

            // Duty counts the logic-one time when non-inverted and the
            // logic-zero time when inverted, so lit time flips with it
            always_comb
            begin
                phase        = (pwm_cnt_reg < level_reg[i]);
                pin_level[i] = phase ^ ~pol_reg[i];
                if (type_reg[i])
                begin
                    pin_next[i].level = pin_level[i];
                    pin_next[i].oe_n  = 1'b0;
                end
                else
                begin
                    // Open-drain: never drive high, the pull-up does it
                    pin_next[i].level = 1'b0;
                    pin_next[i].oe_n  = pin_level[i];
                end
            end

            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    act_reg[i]   <= 1'b0;
                    level_reg[i] <= lamp_drive_pkg::DUTY_ZERO;
                    state_reg[i] <= lamp_drive_pkg::RAMP_HOLD;
                    pin_reg[i]   <= '{level: 1'b0, oe_n: 1'b1};
                end
                else if (ce)
                begin
                    act_reg[i]   <= act_next[i];
                    level_reg[i] <= level_next[i];
                    state_reg[i] <= state_next[i];
                    pin_reg[i]   <= pin_next[i];
                end
            end

            AST_OPEN_DRAIN: assert property (
                ce && !type_reg[i]
                |=> !pin_reg[i].level && pin_reg[i].oe_n == $past(pin_level[i]))
                else $error("Open-drain pin drove high or wrong enable");

            AST_PUSH_PULL: assert property (
                ce && type_reg[i]
                |=> !pin_reg[i].oe_n && pin_reg[i].level == $past(pin_level[i]))
                else $error("Push-pull pin not driven to its level");

            AST_LINKED_TOUCH: assert property (
                ce && link_reg[i] |=> act_reg[i] == $past(touch[i]))
                else $error("Linked lamp does not follow its touch");

            AST_UNLINKED_MANUAL: assert property (
                ce && !link_reg[i] |=> act_reg[i] == $past(manual_reg[i]))
                else $error("Unlinked lamp does not follow manual bit");

            AST_IDLE_MIN: assert property (
                ce && !act_reg[i] |=> level_reg[i] == $past(duty[i].min_duty))
                else $error("Idle lamp not at minimum duty");

            AST_ZERO_DUTY_POL: assert property (
                ce && type_reg[i] && level_reg[i] == lamp_drive_pkg::DUTY_ZERO
                |=> pin_reg[i].level == !$past(pol_reg[i]))
                else $error("Zero duty pin level ignores polarity");

            AST_RAMP_STEP: assert property (
                ce && act_reg[i] && duty[i].breathe && pwm_wrap
                && state_reg[i] == lamp_drive_pkg::RAMP_UP
                && level_reg[i] < duty[i].max_duty
                |=> level_reg[i] == $past(level_reg[i])
                    + lamp_drive_pkg::DUTY_STEP)
                else $error("Breathing ramp did not step up");

            AST_STEADY_MAX: assert property (
                ce && act_reg[i] && !duty[i].breathe
                |=> level_reg[i] == $past(duty[i].max_duty))
                else $error("Steady actuated lamp not at maximum duty");

            AST_RAMP_DOWN: assert property (
                ce && act_reg[i] && duty[i].breathe && pwm_wrap
                && state_reg[i] == lamp_drive_pkg::RAMP_DOWN
                && level_reg[i] > duty[i].min_duty
                |=> level_reg[i] == $past(level_reg[i])
                    - lamp_drive_pkg::DUTY_STEP)
                else $error("Breathing ramp did not step down");
        end
    endgenerate

    // Actuation goes out to the behaviour logic
    assign lamp_actuate_a = act_reg[0];
    assign lamp_actuate_b = act_reg[1];
    assign lamp_out_a     = pin_reg[0];
    assign lamp_out_b     = pin_reg[1];

endmodule

`default_nettype wire

//--- bench/lamp_pullup_model.sv
// Lamp load model: pull-up resistors on the two lamp pin wires
`timescale 1ns/1ps
`default_nettype none

module lamp_pullup_model
(
    input  wire lamp_drive_pkg::pin_drive_t drive_a,
    input  wire lamp_drive_pkg::pin_drive_t drive_b,
    output var  logic [1:0]                 pin_wire
);
    // A released pin floats up through its resistor, so it reads high
    always_comb
    begin
        pin_wire[0] = drive_a.oe_n ? 1'h1 : drive_a.level;
        pin_wire[1] = drive_b.oe_n ? 1'h1 : drive_b.level;
    end
endmodule
`default_nettype wire

//--- bench/lamp_output_drive_control_bench.sv
// Self-checking bench for the lamp output drive control block
`timescale 1ns/1ps
`default_nettype none

module lamp_output_drive_control_bench;
    logic                       clk;
    logic                       arst_n;
    logic                       ce;
    lamp_drive_pkg::reg_req_t   req;
    logic [7:0]                 rdata;
    logic [1:0]                 touch;
    lamp_drive_pkg::lamp_duty_t duty_a;
    lamp_drive_pkg::lamp_duty_t duty_b;
    wire logic [1:0]            act;
    lamp_drive_pkg::pin_drive_t out_a;
    lamp_drive_pkg::pin_drive_t out_b;
    logic [1:0]                 pin_wire;
    int                         n_errors;
    int                         n_compared;

    lamp_output_drive_control u_dut
    (
        .clk            (clk),
        .arst_n         (arst_n),
        .ce             (ce),
        .reg_req        (req),
        .reg_rdata      (rdata),
        .touch_input_a  (touch[0]),
        .touch_input_b  (touch[1]),
        .duty_a         (duty_a),
        .duty_b         (duty_b),
        .lamp_actuate_a (act[0]),
        .lamp_actuate_b (act[1]),
        .lamp_out_a     (out_a),
        .lamp_out_b     (out_b)
    );

    lamp_pullup_model u_load
    (
        .drive_a  (out_a),
        .drive_b  (out_b),
        .pin_wire (pin_wire)
    );

    // 10 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks: comparison, register access, pin measurement
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    // Data lands on the taking edge and then holds; sampled one edge later
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        @(negedge clk);
        d = rdata;
    endtask

    // Lets register, actuation, level and pin stages all settle
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    // One full PWM period: cycles the wire is low and cycles driven
    task automatic measure(input int i, output logic [7:0] low,
                           output logic [7:0] oel);
        lamp_drive_pkg::pin_drive_t o;
        low = 8'h00;
        oel = 8'h00;
        repeat (16)
        begin
            @(negedge clk);
            o = (i == 0) ? out_a : out_b;
            if (pin_wire[i] === 1'h0)
                low++;
            if (o.oe_n === 1'h0)
                oel++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_regs();
        logic [7:0] d;
        logic [7:0] a;
        for (int k = 0; k < 4; k++)
        begin
            a = lamp_drive_pkg::ADDR_DRIVE_TYPE + 8'(k);
            reg_rd(a, d);
            check(d, 8'h00);
            reg_wr(a, 8'hFF);
            reg_rd(a, d);
            check(d, 8'h03);
            reg_wr(a, 8'h00);
        end
        // Unmapped place must stay empty even after a write
        reg_wr(8'h75, 8'hFF);
        reg_rd(8'h75, d);
        check(d, 8'h00);
    endtask

    // Walks one lamp through manual, polarity, type and linking
    task automatic test_lamp(input int i);
        logic [7:0] low;
        logic [7:0] oel;
        logic [7:0] m;
        m = 8'h01 << i;
        @(posedge clk);
        touch <= m[1:0];
        settle();
        measure(i, low, oel);
        check({6'h00, act}, 8'h00);
        check(low, 8'h03);
        reg_wr(lamp_drive_pkg::ADDR_MANUAL, m);
        settle();
        measure(i, low, oel);
        check({6'h00, act}, m);
        check(low, 8'h0C);
        reg_wr(lamp_drive_pkg::ADDR_POLARITY, m);
        settle();
        measure(i, low, oel);
        check(low, 8'h04);
        check(oel, 8'h04);
        reg_wr(lamp_drive_pkg::ADDR_DRIVE_TYPE, m);
        settle();
        measure(i, low, oel);
        check(low, 8'h04);
        check(oel, 8'h10);
        // Linked with no touch: manual bit must lose its hold
        reg_wr(lamp_drive_pkg::ADDR_LINK, m);
        @(posedge clk);
        touch <= 2'h0;
        settle();
        measure(i, low, oel);
        check({6'h00, act}, 8'h00);
        check(low, 8'h0D);
        @(posedge clk);
        touch <= m[1:0];
        settle();
        measure(i, low, oel);
        check({6'h00, act}, m);
        check(low, 8'h04);
        for (int k = 0; k < 4; k++)
            reg_wr(lamp_drive_pkg::ADDR_DRIVE_TYPE + 8'(k), 8'h00);
        @(posedge clk);
        touch <= 2'h0;
    endtask

    // Window edges may straddle steps, so only bounds are exact
    task automatic test_breathe();
        logic [7:0] low;
        logic [7:0] oel;
        logic [7:0] top;
        top = 8'h00;
        @(posedge clk);
        duty_a <= '{breathe: 1'h1, max_duty: 4'h4, min_duty: 4'h2};
        reg_wr(lamp_drive_pkg::ADDR_MANUAL, 8'h01);
        settle();
        repeat (10)
        begin
            measure(0, low, oel);
            if (low > top)
                top = low;
            check((low >= 8'h02 && low <= 8'h04) ? 8'h01 : low, 8'h01);
        end
        check((top > 8'h02) ? 8'h01 : top, 8'h01);
        reg_wr(lamp_drive_pkg::ADDR_MANUAL, 8'h00);
        settle();
        measure(0, low, oel);
        check(low, 8'h02);
    endtask

    // Clock enable freeze, zero duty and a reset in mid-run
    task automatic test_freeze_reset();
        logic [7:0]                 d;
        logic [7:0]                 low;
        logic [7:0]                 oel;
        lamp_drive_pkg::pin_drive_t o;
        // Idle lamp a toggles at minimum duty; with ce low nothing moves
        @(posedge clk);
        ce <= 1'h0;
        @(negedge clk);
        o = out_a;
        reg_wr(lamp_drive_pkg::ADDR_MANUAL, 8'h01);
        repeat (16)
        begin
            @(negedge clk);
            check({6'h00, out_a}, {6'h00, o});
        end
        check({6'h00, act}, 8'h00);
        @(posedge clk);
        ce <= 1'h1;
        reg_rd(lamp_drive_pkg::ADDR_MANUAL, d);
        check(d, 8'h00);
        // Zero duty on a push-pull pin sits at the polarity's idle level
        @(posedge clk);
        duty_a <= '{breathe: 1'h0, max_duty: 4'hC, min_duty: 4'h0};
        reg_wr(lamp_drive_pkg::ADDR_DRIVE_TYPE, 8'h01);
        settle();
        measure(0, low, oel);
        check(low, 8'h00);
        check(oel, 8'h10);
        reg_wr(lamp_drive_pkg::ADDR_POLARITY, 8'h01);
        settle();
        measure(0, low, oel);
        check(low, 8'h10);
        // Leave non-zero state behind so the reset has work to do
        reg_wr(lamp_drive_pkg::ADDR_MANUAL, 8'h01);
        reg_rd(lamp_drive_pkg::ADDR_POLARITY, d);
        check(d, 8'h01);
        check({6'h00, act}, 8'h01);
        // Reset in mid-run: pins released, registers back to zero
        @(posedge clk);
        arst_n <= 1'h0;
        @(negedge clk);
        check({6'h00, out_a}, 8'h01);
        check({6'h00, act}, 8'h00);
        check(rdata, 8'h00);
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        reg_rd(lamp_drive_pkg::ADDR_DRIVE_TYPE, d);
        check(d, 8'h00);
        reg_rd(lamp_drive_pkg::ADDR_POLARITY, d);
        check(d, 8'h00);
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run is under 2000 cycles; this cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    initial
    begin
        ce = 1'h1;
        arst_n = 1'h0;
        req = '0;
        touch = 2'h0;
        duty_a = '{breathe: 1'h0, max_duty: 4'hC, min_duty: 4'h3};
        duty_b = '{breathe: 1'h0, max_duty: 4'hC, min_duty: 4'h3};
        n_errors = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        test_regs();
        test_lamp(0);
        test_lamp(1);
        test_freeze_reset();
        test_breathe();
        end_sim();
    end
endmodule
`default_nettype wire
